// ===== hdl/ulsr_pkg.sv
// Package: constants and types for the receive line status block.
// Assumes one 50 MHz system clock and a plain register port.
package ulsr_pkg;

	// ****************************************
	// Clock and line timing
	// ****************************************
	localparam int CLK_HZ   = 50_000_000;
	localparam int BAUD_BPS = 115_200;
	localparam int BIT_CYC  = CLK_HZ / BAUD_BPS;
	localparam int HALF_CYC = BIT_CYC / 2;
	localparam int CNT_W    = 10;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [31:0] ADDR_RBR  = 32'he001_0000;
	localparam logic [31:0] ADDR_FCR  = 32'he001_0008;
	localparam logic [31:0] ADDR_LSR  = 32'he001_0014;
	localparam logic [31:0] ADDR_IST  = 32'he001_0040;
	localparam logic [31:0] ADDR_IMSK = 32'he001_0044;

	// fifo_control_reg fields
	localparam int FCR_EN   = 0;
	localparam int FCR_RST  = 1;
	localparam int FCR_PEN  = 4;
	localparam int FCR_PODD = 5;
	localparam logic [7:0] FCR_RESET = 8'h00;

	// rx_line_status fields
	localparam int LSR_READY = 0;
	localparam int LSR_OE    = 1;
	localparam int LSR_PAR   = 2;
	localparam int LSR_FRM   = 3;
	localparam int LSR_BRK   = 4;

	// Interrupt status and mask layout: one bit per event
	localparam int IRQ_W = 5;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

	// One received character with its error tags
	typedef struct packed {
		logic       brk;
		logic       frm;
		logic       par;
		logic [7:0] data;
	} ulsr_entry_s;

	// Sticky error flags of the status register
	typedef struct packed {
		logic brk;
		logic frm;
		logic par;
		logic oe;
	} ulsr_flags_s;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_START = 6'b000010,
		ST_DATA  = 6'b000100,
		ST_PAR   = 6'b001000,
		ST_STOP  = 6'b010000,
		ST_BRK   = 6'b100000
	} ulsr_state_e;

endpackage

// ===== hdl/ulsr_rx_status.sv
// Receiver, character FIFO and line status register of a serial port.
// Assumes the register master honours one-cycle strobes, never both.
`timescale 1ns/1ps
module ulsr_rx_status
	import ulsr_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_RST_N,
	// Serial line
	input  wire logic        I_RX_SERIAL_IN,
	// Register port
	input  wire logic [31:0] I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [7:0]  O_RDATA,
	// Interrupt
	output logic             O_IRQ
);

	localparam int PW = $clog2(DEPTH);

	// ****************************************
	// Line synchroniser and receiver
	// ****************************************
	logic              rx_meta_q;
	logic              rx_q;
	ulsr_state_e       state_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [2:0]        idx_q;
	logic [7:0]        shift_q;
	logic              par_err_q;
	logic              zero_q;
	logic [7:0]        fcr_q;
	logic              tick;
	logic              char_done;
	ulsr_entry_s       new_ent;

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			rx_meta_q <= 1'b1;
			rx_q      <= 1'b1;
		end else begin
			rx_meta_q <= I_RX_SERIAL_IN;
			rx_q      <= rx_meta_q;
		end
	end

	assign tick      = (cnt_q == '0);
	assign char_done = (state_q == ST_STOP) && tick;
	assign new_ent   = '{brk: !rx_q && zero_q, frm: !rx_q,
		par: par_err_q, data: shift_q};

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			state_q   <= ST_IDLE;
			cnt_q     <= '0;
			idx_q     <= '0;
			shift_q   <= '0;
			par_err_q <= 1'b0;
			zero_q    <= 1'b0;
		end else begin
			cnt_q <= tick ? CNT_W'(BIT_CYC - 1) : cnt_q - 1'b1;
			unique case (state_q)
				ST_IDLE: begin
					cnt_q <= CNT_W'(HALF_CYC - 1);
					if (!rx_q) begin
						state_q <= ST_START;
						zero_q  <= 1'b1;
					end
				end
				ST_START: if (tick) begin
					// A start bit gone high at mid-bit was a glitch
					state_q   <= rx_q ? ST_IDLE : ST_DATA;
					idx_q     <= '0;
					par_err_q <= 1'b0;
				end
				ST_DATA: if (tick) begin
					shift_q <= {rx_q, shift_q[7:1]};
					zero_q  <= zero_q && !rx_q;
					idx_q   <= idx_q + 1'b1;
					if (idx_q == 3'h7)
						state_q <= fcr_q[FCR_PEN] ? ST_PAR : ST_STOP;
				end
				ST_PAR: if (tick) begin
					par_err_q <= (^shift_q) ^ rx_q ^ fcr_q[FCR_PODD];
					zero_q    <= zero_q && !rx_q;
					state_q   <= ST_STOP;
				end
				ST_STOP: if (tick) begin
					if (rx_q)
						state_q <= ST_IDLE;
					else if (zero_q)
						state_q <= ST_BRK;
					else begin
						// Bad stop bit reused as start, mid-bit already reached
						state_q   <= ST_DATA;
						idx_q     <= '0;
						zero_q    <= 1'b1;
						par_err_q <= 1'b0;
					end
				end
				ST_BRK: if (rx_q)
					state_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Receive FIFO
	// ****************************************
	ulsr_entry_s       mem_q [DEPTH];
	logic [PW-1:0]     wr_q;
	logic [PW-1:0]     rd_q;
	logic [PW:0]       count_q;
	logic              fifo_en;
	logic              full;
	logic              push;
	logic              pop;
	logic              flush;
	logic              ovr_evt;
	logic              rd_lsr;
	logic              wr_fcr;

	assign fifo_en = fcr_q[FCR_EN];
	// With the FIFO off it behaves as a single holding register
	assign full    = fifo_en ? (count_q == (PW+1)'(DEPTH))
		: (count_q != '0);
	assign pop     = I_RD && (I_ADDR == ADDR_RBR) && (count_q != '0);
	assign ovr_evt = char_done && full;
	assign push    = char_done && !full;
	assign rd_lsr  = I_RD && (I_ADDR == ADDR_LSR);
	assign wr_fcr  = I_WR && (I_ADDR == ADDR_FCR);
	// Changing the enable empties the FIFO, as does the reset bit
	assign flush   = wr_fcr && (I_WDATA[FCR_RST] ||
		(I_WDATA[FCR_EN] != fcr_q[FCR_EN]));

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			fcr_q <= FCR_RESET;
		else if (wr_fcr)
			fcr_q <= I_WDATA & ~(8'h01 << FCR_RST);
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			wr_q    <= '0;
			rd_q    <= '0;
			count_q <= '0;
		end else if (flush) begin
			wr_q    <= '0;
			rd_q    <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				mem_q[wr_q] <= new_ent;
				wr_q        <= wr_q + 1'b1;
			end
			if (pop)
				rd_q <= rd_q + 1'b1;
			count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// ****************************************
	// Line status flags
	// ****************************************
	ulsr_flags_s       lsr_q;
	ulsr_flags_s       set_f;
	logic              head_new;
	ulsr_entry_s       head_ent;

	// A new head is the pushed entry when the FIFO was or becomes empty
	always_comb begin
		head_new = 1'b0;
		head_ent = mem_q[rd_q + 1'b1];
		if (push && (count_q == '0 || (pop && count_q == 1))) begin
			head_new = 1'b1;
			head_ent = new_ent;
		end else if (pop && count_q > 1)
			head_new = 1'b1;
	end

	always_comb begin
		set_f    = '0;
		set_f.oe = ovr_evt;
		if (fifo_en) begin
			// Reported when the character reaches the head
			set_f.par = head_new && !flush && head_ent.par;
			set_f.frm = head_new && !flush && head_ent.frm;
			set_f.brk = head_new && !flush && head_ent.brk;
		end else begin
			// Reported as soon as the character is received
			set_f.par = push && new_ent.par;
			set_f.frm = push && new_ent.frm;
			set_f.brk = push && new_ent.brk;
		end
	end

	// Writes never reach these flags; only reads clear them
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			lsr_q <= '0;
		else
			lsr_q <= set_f | (rd_lsr ? '0 : lsr_q);
	end

	// ****************************************
	// Interrupts and read data
	// ****************************************
	logic [IRQ_W-1:0]  ist_q;
	logic [IRQ_W-1:0]  imsk_q;
	logic [IRQ_W-1:0]  ev;
	logic [7:0]        rd_d;

	assign ev = {set_f.brk, set_f.frm, set_f.par, set_f.oe, push};

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			ist_q <= IRQ_RESET;
		else
			ist_q <= ev | ((I_RD && I_ADDR == ADDR_IST) ? '0 : ist_q);
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			imsk_q <= IRQ_RESET;
		else if (I_WR && I_ADDR == ADDR_IMSK)
			imsk_q <= I_WDATA[IRQ_W-1:0];
	end

	assign O_IRQ = |(ist_q & imsk_q);

	always_comb begin
		rd_d = 8'h00;
		unique case (I_ADDR)
			ADDR_RBR:  rd_d = (count_q != '0) ? mem_q[rd_q].data : 8'h00;
			ADDR_FCR:  rd_d = fcr_q;
			ADDR_LSR:  rd_d = {3'h0, lsr_q, count_q != '0};
			ADDR_IST:  rd_d = {3'h0, ist_q};
			ADDR_IMSK: rd_d = {3'h0, imsk_q};
			default:   rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N)
			O_RDATA <= 8'h00;
		else
			O_RDATA <= I_RD ? rd_d : 8'h00;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	a_lsr_write_ignored: assert property (
		I_WR && I_ADDR == ADDR_LSR && set_f == '0
		|=> lsr_q == $past(lsr_q))
		else $error("write altered status register");
	a_ready_empty_read: assert property (
		pop && count_q == 1 && !push && !flush ##1 !push ##1 rd_lsr
		|=> !O_RDATA[LSR_READY])
		else $error("data ready wrong");
	a_ready_after_push: assert property (
		push && !flush ##1 I_RD && I_ADDR == ADDR_LSR |=> O_RDATA[LSR_READY])
		else $error("data ready missing after push");
	a_overrun_set: assert property (
		ovr_evt |=> lsr_q.oe)
		else $error("overrun flag not raised");
	a_overrun_keeps: assert property (
		ovr_evt && !pop && !flush |=> count_q == $past(count_q)
		&& wr_q == $past(wr_q))
		else $error("fifo altered on overrun");
	a_read_clears: assert property (
		rd_lsr && set_f == '0 |=> lsr_q == '0)
		else $error("status read did not clear flags");
	a_parity_now: assert property (
		!fifo_en && push && new_ent.par |=> lsr_q.par)
		else $error("parity flag not raised");
	a_head_tags: assert property (
		fifo_en && head_new && !flush && head_ent.frm |=> lsr_q.frm)
		else $error("head framing flag not raised");
	a_frame_flag: assert property (
		!fifo_en && char_done && !rx_q && !full |=> lsr_q.frm)
		else $error("framing flag not raised");
	a_frame_resync: assert property (
		char_done && !rx_q && !zero_q |=> state_q == ST_DATA
		&& idx_q == '0)
		else $error("no resync after framing error");
	a_break_flag: assert property (
		!fifo_en && char_done && !rx_q && zero_q && !full |=> lsr_q.brk
		&& state_q == ST_BRK)
		else $error("break not detected");
	a_break_idle: assert property (
		state_q == ST_BRK && !rx_q |=> state_q == ST_BRK && !push)
		else $error("receiver left break while line low");
	a_set_wins: assert property (
		rd_lsr && ovr_evt |=> lsr_q.oe)
		else $error("flag lost to clearing read");

	c_overrun: cover property (ovr_evt);
	c_resync:  cover property (char_done && !rx_q && !zero_q);
	c_break:   cover property (state_q == ST_STOP ##1 state_q == ST_BRK);
	c_parity:  cover property (set_f.par);

endmodule // ulsr_rx_status

// ===== test/ulsr_tx_model.sv
// Remote serial transmitter model that drives the block's receive line.
// Assumes the package bit time and the free-running system clock.
`timescale 1ns/1ps
module ulsr_tx_model
	import ulsr_pkg::*;
(
	// Clock
	input  wire logic i_clk,
	// Serial line, idles at the marking level
	output logic      o_line
);
	initial o_line = 1'b1;

	// Drive one level for n bit times, changed just after an edge
	task automatic hold(input logic v, input int n);
		@(posedge i_clk);
		o_line <= v;
		repeat (n * BIT_CYC - 1) @(posedge i_clk);
	endtask

	// Start, eight data bits LSB first, optional parity, one stop
	task automatic send(input logic [7:0] d, input logic pen,
		input logic pb, input logic sb);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) hold(d[i], 1);
		if (pen) hold(pb, 1);
		// A low stop here is a deliberate framing fault
		hold(sb, 1);
		o_line <= 1'b1;
	endtask
endmodule // ulsr_tx_model

// ===== test/uart_rx_line_status_test.sv
// Self-checking bench for the receive line status block.
// Assumes the transmitter model above; FIFO depth cut to 2 for speed.
`timescale 1ns/1ps
module uart_rx_line_status_test;
	import ulsr_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        wr;
	logic        rd;
	logic [31:0] addr;
	logic [7:0]  wd;
	logic [7:0]  rdata;
	logic [7:0]  v;
	logic        irq;
	logic        line;
	int          err_total;
	int          total_checks;

	ulsr_rx_status #(.DEPTH(2)) dut (.I_CLK_SYS(clk), .I_RST_N(rst_n),
		.I_RX_SERIAL_IN(line), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq));
	ulsr_tx_model tx (.i_clk(clk), .o_line(line));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ****************************************
	// Bus and compare helpers
	// ****************************************
	task automatic wrr(input logic [31:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [31:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t expected %h got %h", $time, e, g);
		end
	endtask

	task automatic rc(input logic [31:0] a, input logic [7:0] e);
		rd_reg(a, v);
		chk(e, v);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		rc(ADDR_LSR, 8'h00);
		wrr(ADDR_LSR, 8'h1f);
		rc(ADDR_LSR, 8'h00);
		rc(32'he001_00f0, 8'h00);
		rc(ADDR_FCR, 8'h00);
		$display("t_regs done");
	endtask

	task automatic t_rx;
		tx.send(8'ha5, 1'b0, 1'b0, 1'b1);
		@(negedge clk);
		chk(8'h00, {7'h00, irq});
		rc(ADDR_LSR, 8'h01);
		wrr(ADDR_IMSK, 8'h01);
		@(negedge clk);
		chk(8'h01, {7'h00, irq});
		rc(ADDR_IST, 8'h01);
		chk(8'h00, {7'h00, irq});
		rc(ADDR_RBR, 8'ha5);
		rc(ADDR_LSR, 8'h00);
		$display("t_rx done");
	endtask

	// FIFO off holds one character, so the second one overruns
	task automatic t_ovr;
		tx.send(8'h11, 1'b0, 1'b0, 1'b1);
		tx.send(8'h22, 1'b0, 1'b0, 1'b1);
		rc(ADDR_LSR, 8'h03);
		rc(ADDR_LSR, 8'h01);
		rc(ADDR_RBR, 8'h11);
		rc(ADDR_LSR, 8'h00);
		$display("t_ovr done");
	endtask

	// Bad parity on the second character shows only once it is at the head
	task automatic t_par;
		wrr(ADDR_FCR, 8'h11);
		tx.send(8'h03, 1'b1, 1'b0, 1'b1);
		tx.send(8'h01, 1'b1, 1'b0, 1'b1);
		rc(ADDR_LSR, 8'h01);
		rc(ADDR_RBR, 8'h03);
		rc(ADDR_LSR, 8'h05);
		rc(ADDR_RBR, 8'h01);
		wrr(ADDR_FCR, 8'h31);
		tx.send(8'h01, 1'b1, 1'b0, 1'b1);
		rc(ADDR_LSR, 8'h01);
		rc(ADDR_RBR, 8'h01);
		// FIFO off: a bad parity shows as soon as the character lands
		wrr(ADDR_FCR, 8'h10);
		tx.send(8'h01, 1'b1, 1'b0, 1'b1);
		rc(ADDR_LSR, 8'h05);
		rc(ADDR_RBR, 8'h01);
		$display("t_par done");
	endtask

	// Low stop is taken as a start, so an all-ones character follows
	task automatic t_frm;
		wrr(ADDR_FCR, 8'h01);
		tx.send(8'h55, 1'b0, 1'b0, 1'b0);
		repeat (10 * BIT_CYC) @(posedge clk);
		rc(ADDR_LSR, 8'h09);
		rc(ADDR_RBR, 8'h55);
		rc(ADDR_RBR, 8'hff);
		$display("t_frm done");
	endtask

	// A long low yields exactly one break character
	task automatic t_brk;
		wrr(ADDR_FCR, 8'h00);
		tx.hold(1'b0, 25);
		tx.hold(1'b1, 2);
		rc(ADDR_LSR, 8'h19);
		rc(ADDR_RBR, 8'h00);
		rc(ADDR_LSR, 8'h00);
		$display("t_brk done");
	endtask

	initial begin
		err_total = 0;
		total_checks = 0;
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 32'h0000_0000;
		wd = 8'h00;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs;
		t_rx;
		t_ovr;
		t_par;
		t_frm;
		t_brk;
		end_sim;
	end

	// About 53k cycles are expected; stop at 80k
	initial begin
		#1_600_000;
		err_total++;
		end_sim;
	end
endmodule // uart_rx_line_status_test
